/* File: core/rmp_div_if.sv */
`timescale 1ns/1ps
interface rmp_div_if;
    logic start;
    logic [39:0] dividend;
    logic [23:0] divisor;
    logic done;
    logic [15:0] quotient;
    modport req (output start, dividend, divisor, input done, quotient);
    modport div (input start, dividend, divisor, output done, quotient);
endinterface : rmp_div_if

/* File: core/rmp_divider.sv */
`timescale 1ns/1ps
module rmp_divider (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request side
    rmp_div_if.div dv
);
    logic [39:0] quo_q;
    logic [23:0] rem_q;
    logic [23:0] den_q;
    logic [5:0] cnt_q;
    logic busy_q;
    logic done_q;
    wire [24:0] shifted = {rem_q, quo_q[39]};
    wire [24:0] trial = shifted - {1'b0, den_q};

    // Restoring division, one quotient bit per cycle; start while busy is ignored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            quo_q <= 40'h0;
            rem_q <= 24'h0;
            den_q <= 24'h0;
            cnt_q <= 6'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (!busy_q && dv.start) begin
                quo_q <= dv.dividend;
                rem_q <= 24'h0;
                den_q <= dv.divisor;
                cnt_q <= rmp_pkg::DIV_STEPS;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                rem_q <= trial[24] ? shifted[23:0] : trial[23:0];
                quo_q <= {quo_q[38:0], ~trial[24]};
                cnt_q <= cnt_q - 6'h1;
                if (cnt_q == 6'h1) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

    assign dv.done = done_q;
    assign dv.quotient = quo_q[15:0];
endmodule : rmp_divider

/* File: core/rmp_pkg.sv */
package rmp_pkg;
    localparam int NBIN = 256;
    localparam int DIVN_W = 40;
    localparam int DIVD_W = 24;
    localparam int Q_W = 16;
    localparam logic [5:0] DIV_STEPS = 6'h28;
    localparam logic [9:0] LEN_MIN = 10'h001;
    localparam logic [9:0] LEN_MAX = 10'h3E8;
    localparam logic [6:0] SENS_MAX = 7'h64;
    // Amplitude per sensitivity step, so 100 lands near full scale
    localparam logic [9:0] SENS_SCALE = 10'h28F;
    // 10*log10(2) in 0.01 dB units
    localparam logic [8:0] TENLOG_CDB = 9'h12D;
    localparam int LOG_FRAC = 4;
    localparam logic [15:0] SNR_SAT = 16'hFFFF;
    localparam int VEL_RATE_HZ = 10;
    localparam int SELFCFG_TIME_S = 3;
    localparam int SELFCFG_READINGS = SELFCFG_TIME_S * VEL_RATE_HZ;
    localparam logic [16:0] IIR_ONE = 17'h10000;
    localparam int IIR_FRAC = 16;
    // n*205>>11 equals n/10 for every n up to 1000
    localparam logic [7:0] TRIM_MUL = 8'hCD;
    localparam int TRIM_SH = 11;
    typedef enum logic [1:0] {
        DIR_IN = 2'h0,
        DIR_OUT = 2'h1,
        DIR_BOTH = 2'h2
    } rmp_dir_type;
    typedef enum logic [2:0] {
        LF_NONE = 3'h0,
        LF_IIR = 3'h1,
        LF_MAVG = 3'h2,
        LF_MEDIAN = 3'h3,
        LF_TRIM = 3'h4
    } rmp_lfilt_type;
    typedef enum logic [1:0] {
        PK_MAX = 2'h0,
        PK_LAST = 2'h1,
        PK_FIRST = 2'h2
    } rmp_lpeak_type;
endpackage : rmp_pkg

/* File: core/rmp_postprocess.sv */
`timescale 1ns/1ps
module rmp_postprocess (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Velocity settings
    input wire logic [6:0] sens_thld,
    input wire logic [12:0] snr_thld,
    input wire logic [9:0] vel_filter_len,
    input wire logic [1:0] direction_sel,
    input wire logic fast_start,
    input wire logic [1:0] peak_width,
    // Level settings
    input wire logic [2:0] lvl_filter_type,
    input wire logic [9:0] lvl_filter_len,
    input wire logic [16:0] recursive_coefficient_cmd,
    input wire logic [15:0] lvl_amp_thld,
    input wire logic [1:0] lvl_peak_sel,
    // Velocity spectrum stream
    input wire logic vel_bin_valid,
    output logic vel_bin_ready,
    input wire logic [15:0] vel_bin_amp,
    input wire logic signed [15:0] vel_bin_speed,
    input wire logic vel_bin_last,
    // Level echo stream
    input wire logic lvl_bin_valid,
    output logic lvl_bin_ready,
    input wire logic [15:0] lvl_bin_amp,
    input wire logic [15:0] lvl_bin_dist,
    input wire logic lvl_bin_last,
    // Velocity results
    output logic vel_out_valid,
    output logic vel_flow_ok,
    output logic vel_dir_out,
    output logic [15:0] vel_snr,
    output logic signed [15:0] vel_raw,
    output logic signed [15:0] vel_avg,
    // Level results
    output logic lvl_out_valid,
    output logic [15:0] lvl_raw,
    output logic [15:0] lvl_out
);
    typedef enum logic [3:0] {
        V_COLLECT = 4'h1, V_WIDTH = 4'h2, V_CDIV = 4'h4, V_ADIV = 4'h8
    } rmp_vstate_type;
    typedef enum logic [3:0] {
        L_COLLECT = 4'h1, L_FILT = 4'h2, L_RANK = 4'h4, L_DIV = 4'h8
    } rmp_lstate_type;

    function automatic logic [9:0] len_clamp(input logic [9:0] len);
        return (len < rmp_pkg::LEN_MIN) ? rmp_pkg::LEN_MIN :
               (len > rmp_pkg::LEN_MAX) ? rmp_pkg::LEN_MAX : len;
    endfunction : len_clamp

    // Integer log2 with four linear mantissa bits; about 0.4 dB worst error
    function automatic logic [9:0] log2_q4(input logic [39:0] x);
        logic [5:0] p;
        logic [39:0] s;
        p = 6'h0;
        for (int b = 0; b < 40; b++) begin
            if (x[b]) p = 6'(b);
        end
        s = x << (6'd39 - p);
        return {p, s[38:35]};
    endfunction : log2_q4

    rmp_div_if div_bus[2] ();
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_div
            rmp_divider u_div (.clk(clk), .rst_n(rst_n), .dv(div_bus[g]));
        end
    endgenerate

    // Velocity path state
    rmp_vstate_type vst_q;
    logic [8:0] vcnt_q;
    logic [23:0] vsum_q;
    logic [15:0] vpk_amp_q;
    logic [7:0] vpk_idx_q;
    logic vpk_ok_q;
    logic [2:0] vkk_q;
    logic signed [39:0] vnum_q;
    logic [23:0] vden_q;
    logic vdiv_go_q, vneg_q;
    logic [39:0] vdiv_n_q;
    logic [23:0] vdiv_d_q;
    logic [9:0] vwp_q, vhcnt_q, vlen_q;
    logic signed [26:0] vhsum_q;
    logic [4:0] vwarm_q;
    logic vout_v_q, vok_q, vdir_q;
    logic [15:0] vsnr_q;
    logic signed [15:0] vraw_q, vavg_q;
    logic [15:0] vamp_mem [rmp_pkg::NBIN];
    logic signed [15:0] vspd_mem [rmp_pkg::NBIN];
    logic signed [15:0] vhist [1024];

    wire vel_take = vel_bin_valid && vel_bin_ready;
    wire v_room = !vcnt_q[8];
    wire v_dir_ok = (direction_sel == rmp_pkg::DIR_BOTH) ||
                    (direction_sel == rmp_pkg::DIR_IN && !vel_bin_speed[15]) ||
                    (direction_sel == rmp_pkg::DIR_OUT && vel_bin_speed[15]);
    wire v_beats = v_room && v_dir_ok && (vel_bin_amp > vpk_amp_q);
    wire signed [10:0] v_widx = $signed({3'h0, vpk_idx_q}) - $signed({9'h0, peak_width})
                              + $signed({8'h0, vkk_q});
    wire v_in = !v_widx[10] && (v_widx[9:0] < {1'b0, vcnt_q});
    wire [7:0] v_ri = v_widx[7:0];
    wire signed [32:0] v_prod = $signed({1'b0, vamp_mem[v_ri]}) * vspd_mem[v_ri];
    wire signed [39:0] v_num_n = vnum_q + (v_in ? 40'(v_prod) : 40'sh0);
    wire [23:0] v_den_n = vden_q + (v_in ? {8'h0, vamp_mem[v_ri]} : 24'h0);
    wire v_wdone = (vkk_q == {peak_width, 1'b0});
    // SNR from peak and the rest of the spectrum
    wire [23:0] v_noise = vsum_q - {8'h0, vpk_amp_q};
    wire [24:0] v_sig = vpk_amp_q * (vcnt_q - 9'h1);
    wire signed [10:0] v_ldiff = $signed({1'b0, log2_q4({15'h0, v_sig})})
                               - $signed({1'b0, log2_q4({16'h0, v_noise})});
    wire [19:0] v_scaled = 20'(v_ldiff[9:0]) * 20'(rmp_pkg::TENLOG_CDB);
    wire [15:0] v_snr = (v_noise == 24'h0) ? rmp_pkg::SNR_SAT :
                        v_ldiff[10] ? 16'h0 : 16'(v_scaled >> rmp_pkg::LOG_FRAC);
    wire [6:0] v_sens = (sens_thld > rmp_pkg::SENS_MAX) ? rmp_pkg::SENS_MAX : sens_thld;
    wire [16:0] v_sens_amp = 17'(v_sens) * 17'(rmp_pkg::SENS_SCALE);
    wire v_loud = vpk_ok_q && ({1'b0, vpk_amp_q} >= v_sens_amp);
    wire v_flow = v_loud && (v_snr >= {3'h0, snr_thld});
    wire v_warming = !fast_start && (vwarm_q < 5'(rmp_pkg::SELFCFG_READINGS));
    wire [39:0] v_num_abs = v_num_n[39] ? 40'(-v_num_n) : 40'(v_num_n);

    wire [9:0] v_len = len_clamp(vel_filter_len);
    wire v_chg = (v_len != vlen_q);
    wire [9:0] v_hcnt_b = v_chg ? 10'h0 : vhcnt_q;
    wire [9:0] v_wp_b = v_chg ? 10'h0 : vwp_q;
    wire signed [26:0] v_hsum_b = v_chg ? 27'sh0 : vhsum_q;
    wire v_full = (v_hcnt_b >= v_len);
    wire signed [15:0] v_old = vhist[10'(v_wp_b - v_len)];
    wire signed [15:0] v_q0 = $signed(div_bus[0].quotient);
    wire signed [15:0] v_cent = vneg_q ? -v_q0 : v_q0;
    wire signed [26:0] v_hsum_n = v_hsum_b + 27'(v_cent) - (v_full ? 27'(v_old) : 27'sh0);
    wire [9:0] v_hcnt_n = v_full ? v_hcnt_b : v_hcnt_b + 10'h1;
    wire [26:0] v_hsum_abs = v_hsum_n[26] ? 27'(-v_hsum_n) : 27'(v_hsum_n);

    assign vel_bin_ready = (vst_q == V_COLLECT);
    assign div_bus[0].start = vdiv_go_q;
    assign div_bus[0].dividend = vdiv_n_q;
    assign div_bus[0].divisor = vdiv_d_q;

    always_ff @(posedge clk) begin
        if (vel_take && v_room) begin
            vamp_mem[vcnt_q[7:0]] <= vel_bin_amp;
            vspd_mem[vcnt_q[7:0]] <= vel_bin_speed;
        end
        if (vst_q == V_CDIV && div_bus[0].done) begin
            vhist[v_wp_b] <= v_cent;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vst_q <= V_COLLECT;
            {vcnt_q, vsum_q, vpk_amp_q, vpk_idx_q, vpk_ok_q, vkk_q} <= '0;
            {vnum_q, vden_q, vdiv_go_q, vneg_q, vdiv_n_q, vdiv_d_q} <= '0;
            {vwp_q, vhcnt_q, vhsum_q, vwarm_q} <= '0;
            vlen_q <= rmp_pkg::LEN_MIN;
            {vout_v_q, vok_q, vdir_q, vsnr_q, vraw_q, vavg_q} <= '0;
        end else begin
            vdiv_go_q <= 1'b0;
            vout_v_q <= 1'b0;
            case (vst_q)
                V_COLLECT: if (vel_take) begin
                    if (v_room) vcnt_q <= vcnt_q + 9'h1;
                    vsum_q <= vsum_q + {8'h0, vel_bin_amp};
                    if (v_beats) begin
                        vpk_amp_q <= vel_bin_amp;
                        vpk_idx_q <= vcnt_q[7:0];
                        vpk_ok_q <= 1'b1;
                    end
                    if (vel_bin_last) begin
                        vkk_q <= 3'h0;
                        vst_q <= V_WIDTH;
                    end
                end
                V_WIDTH: begin
                    vnum_q <= v_num_n;
                    vden_q <= v_den_n;
                    vkk_q <= vkk_q + 3'h1;
                    if (v_wdone) begin
                        {vcnt_q, vsum_q, vpk_amp_q, vpk_ok_q, vnum_q, vden_q} <= '0;
                        if (v_warming) vwarm_q <= vwarm_q + 5'h1;
                        vsnr_q <= v_snr;
                        vdir_q <= v_flow && v_num_n[39];
                        vneg_q <= v_num_n[39];
                        vdiv_n_q <= v_num_abs;
                        vdiv_d_q <= v_den_n;
                        if (v_flow && !v_warming) begin
                            vdiv_go_q <= 1'b1;
                            vst_q <= V_CDIV;
                        end else begin
                            vout_v_q <= !v_warming;
                            vok_q <= 1'b0;
                            vraw_q <= 16'sh0;
                            vavg_q <= 16'sh0;
                            vst_q <= V_COLLECT;
                        end
                    end
                end
                V_CDIV: if (div_bus[0].done) begin
                    vwp_q <= v_wp_b + 10'h1;
                    vhcnt_q <= v_hcnt_n;
                    vhsum_q <= v_hsum_n;
                    vlen_q <= v_len;
                    vraw_q <= v_cent;
                    vneg_q <= v_hsum_n[26];
                    vdiv_n_q <= {13'h0, v_hsum_abs};
                    vdiv_d_q <= {14'h0, v_hcnt_n};
                    vdiv_go_q <= 1'b1;
                    vst_q <= V_ADIV;
                end
                V_ADIV: if (div_bus[0].done) begin
                    vavg_q <= vneg_q ? -v_q0 : v_q0;
                    vok_q <= 1'b1;
                    vout_v_q <= 1'b1;
                    vst_q <= V_COLLECT;
                end
                default: vst_q <= V_COLLECT;
            endcase
        end
    end

    // Level path state
    rmp_lstate_type lst_q;
    logic [15:0] lbest_q, ldist_q, liir_q, lraw_q, lout_q;
    logic lfound_q, liir_ok_q, lout_v_q, ldiv_go_q;
    logic [2:0] ltype_q;
    logic [9:0] llen_q, lwp_q, lhcnt_q, lbase_q, ln_q, li_q, lj_q, lrank_q, ltcnt_q;
    logic [25:0] lhsum_q, ltsum_q;
    logic [39:0] ldiv_n_q;
    logic [23:0] ldiv_d_q;
    logic [15:0] lhist [1024];

    wire lvl_take = lvl_bin_valid && lvl_bin_ready;
    wire l_over = lvl_bin_amp > lvl_amp_thld;
    wire l_pick = l_over && ((lvl_peak_sel == rmp_pkg::PK_LAST) ||
                  (lvl_peak_sel == rmp_pkg::PK_FIRST && !lfound_q) ||
                  (lvl_peak_sel[1] == lvl_peak_sel[0] && lvl_bin_amp > lbest_q));
    wire [15:0] l_raw = lfound_q ? ldist_q : 16'h0;
    wire [9:0] l_len = len_clamp(lvl_filter_len);
    wire l_chg = (l_len != llen_q) || (lvl_filter_type != ltype_q);
    wire [9:0] l_hcnt_b = l_chg ? 10'h0 : lhcnt_q;
    wire [9:0] l_wp_b = l_chg ? 10'h0 : lwp_q;
    wire [25:0] l_hsum_b = l_chg ? 26'h0 : lhsum_q;
    wire l_full = (l_hcnt_b >= l_len);
    wire [15:0] l_old = lhist[10'(l_wp_b - l_len)];
    wire [25:0] l_hsum_n = l_hsum_b + {10'h0, l_raw} - (l_full ? {10'h0, l_old} : 26'h0);
    wire [9:0] l_hcnt_n = l_full ? l_hcnt_b : l_hcnt_b + 10'h1;
    wire [16:0] l_coef = (recursive_coefficient_cmd > rmp_pkg::IIR_ONE) ?
                         rmp_pkg::IIR_ONE : recursive_coefficient_cmd;
    wire signed [17:0] l_diff = $signed({2'h0, l_raw}) - $signed({2'h0, liir_q});
    wire signed [35:0] l_step = l_diff * $signed({1'b0, l_coef});
    wire [15:0] l_iir_n = (l_chg || !liir_ok_q) ? l_raw :
                          16'($signed({2'h0, liir_q}) + 18'(l_step >>> rmp_pkg::IIR_FRAC));
    // Ranking: O(n^2) compares, ~1e6 cycles at length 1000, well inside 1 s
    wire [15:0] l_xi = lhist[10'(lbase_q + li_q)];
    wire [15:0] l_xj = lhist[10'(lbase_q + lj_q)];
    wire l_less = (l_xj < l_xi) || (l_xj == l_xi && lj_q < li_q);
    wire [9:0] l_rank_f = lrank_q + {9'h0, l_less};
    wire [19:0] l_tmul = 20'(ln_q) * 20'(rmp_pkg::TRIM_MUL);
    wire [9:0] l_trim = 10'(l_tmul >> rmp_pkg::TRIM_SH);
    wire l_keep = (l_rank_f >= l_trim) && (l_rank_f < ln_q - l_trim);
    wire [25:0] l_tsum_n = ltsum_q + (l_keep ? {10'h0, l_xi} : 26'h0);
    wire [9:0] l_tcnt_n = ltcnt_q + {9'h0, l_keep};
    wire l_jend = (lj_q == ln_q - 10'h1);
    wire l_iend = (li_q == ln_q - 10'h1);

    assign lvl_bin_ready = (lst_q == L_COLLECT);
    assign div_bus[1].start = ldiv_go_q;
    assign div_bus[1].dividend = ldiv_n_q;
    assign div_bus[1].divisor = ldiv_d_q;

    always_ff @(posedge clk) begin
        if (lst_q == L_FILT) lhist[l_wp_b] <= l_raw;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lst_q <= L_COLLECT;
            {lbest_q, ldist_q, lfound_q, liir_q, liir_ok_q, ltype_q} <= '0;
            {lwp_q, lhcnt_q, lhsum_q, lbase_q, ln_q, li_q, lj_q, lrank_q} <= '0;
            {ltsum_q, ltcnt_q, ldiv_go_q, ldiv_n_q, ldiv_d_q} <= '0;
            llen_q <= rmp_pkg::LEN_MIN;
            {lout_v_q, lraw_q, lout_q} <= '0;
        end else begin
            ldiv_go_q <= 1'b0;
            lout_v_q <= 1'b0;
            case (lst_q)
                L_COLLECT: if (lvl_take) begin
                    if (l_pick) begin
                        ldist_q <= lvl_bin_dist;
                        lbest_q <= lvl_bin_amp;
                        lfound_q <= 1'b1;
                    end
                    if (lvl_bin_last) lst_q <= L_FILT;
                end
                L_FILT: begin
                    {lbest_q, ldist_q, lfound_q} <= '0;
                    lraw_q <= l_raw;
                    ltype_q <= lvl_filter_type;
                    llen_q <= l_len;
                    lwp_q <= l_wp_b + 10'h1;
                    lhcnt_q <= l_hcnt_n;
                    lhsum_q <= l_hsum_n;
                    {li_q, lj_q, lrank_q, ltsum_q, ltcnt_q} <= '0;
                    ln_q <= l_hcnt_n;
                    lbase_q <= 10'(l_wp_b + 10'h1 - l_hcnt_n);
                    ldiv_n_q <= {14'h0, l_hsum_n};
                    ldiv_d_q <= {14'h0, l_hcnt_n};
                    lst_q <= L_COLLECT;
                    case (lvl_filter_type)
                        rmp_pkg::LF_IIR: begin
                            liir_q <= l_iir_n;
                            liir_ok_q <= 1'b1;
                            lout_q <= l_iir_n;
                            lout_v_q <= 1'b1;
                        end
                        rmp_pkg::LF_MAVG: begin
                            ldiv_go_q <= 1'b1;
                            lst_q <= L_DIV;
                        end
                        rmp_pkg::LF_MEDIAN, rmp_pkg::LF_TRIM: lst_q <= L_RANK;
                        default: begin
                            lout_q <= l_raw;
                            lout_v_q <= 1'b1;
                        end
                    endcase
                end
                L_RANK: if (!l_jend) begin
                    lj_q <= lj_q + 10'h1;
                    lrank_q <= l_rank_f;
                end else begin
                    lj_q <= 10'h0;
                    lrank_q <= 10'h0;
                    li_q <= li_q + 10'h1;
                    ltsum_q <= l_tsum_n;
                    ltcnt_q <= l_tcnt_n;
                    if (ltype_q == rmp_pkg::LF_MEDIAN && l_rank_f == (ln_q - 10'h1) >> 1) begin
                        lout_q <= l_xi;
                        lout_v_q <= 1'b1;
                        lst_q <= L_COLLECT;
                    end else if (l_iend) begin
                        ldiv_n_q <= {14'h0, l_tsum_n};
                        ldiv_d_q <= {14'h0, l_tcnt_n};
                        ldiv_go_q <= 1'b1;
                        lst_q <= L_DIV;
                    end
                end
                L_DIV: if (div_bus[1].done) begin
                    lout_q <= div_bus[1].quotient;
                    lout_v_q <= 1'b1;
                    lst_q <= L_COLLECT;
                end
                default: lst_q <= L_COLLECT;
            endcase
        end
    end

    assign vel_out_valid = vout_v_q;
    assign vel_flow_ok = vok_q;
    assign vel_dir_out = vdir_q;
    assign vel_snr = vsnr_q;
    assign vel_raw = vraw_q;
    assign vel_avg = vavg_q;
    assign lvl_out_valid = lout_v_q;
    assign lvl_raw = lraw_q;
    assign lvl_out = lout_q;
endmodule : rmp_postprocess

/* File: verification/radar_measurement_postprocess_bench.sv */
`timescale 1ns/1ps
module radar_measurement_postprocess_bench;
    logic clk = 0, rst_n = 0, lv, lr, ll, vv, vr, vl, vo, fo, dro, lo;
    logic [2:0] ltype = 3'h0;
    logic [16:0] coef = 17'h00000;
    logic [1:0] psel = 2'h0, dsel = 2'h0, pw = 2'h0;
    logic [15:0] lamp = 16'h8000;
    logic [15:0] la, ld, va, snr, lraw, lout;
    logic signed [15:0] vs, vraw, vavg;
    integer seed = 32'h10D6, bad_count = 0, checks_done = 0, cyc = 0;
    int q[$];
    longint y;
    initial forever #12.5 clk = ~clk;
    rmp_postprocess i_dut (.clk, .rst_n, .sens_thld(7'h32), .snr_thld(13'h0000),
        .vel_filter_len(10'h001), .direction_sel(dsel), .fast_start(1'b1), .peak_width(pw),
        .lvl_filter_type(ltype), .lvl_filter_len(10'h003), .recursive_coefficient_cmd(coef),
        .lvl_amp_thld(lamp), .lvl_peak_sel(psel), .vel_bin_valid(vv), .vel_bin_ready(vr),
        .vel_bin_amp(va), .vel_bin_speed(vs), .vel_bin_last(vl), .lvl_bin_valid(lv),
        .lvl_bin_ready(lr), .lvl_bin_amp(la), .lvl_bin_dist(ld), .lvl_bin_last(ll),
        .vel_out_valid(vo), .vel_flow_ok(fo), .vel_dir_out(dro), .vel_snr(snr), .vel_raw(vraw),
        .vel_avg(vavg), .lvl_out_valid(lo), .lvl_raw(lraw), .lvl_out(lout));
    rmp_front_model i_lfe (.clk, .ready(lr), .valid(lv), .amp(la), .dat(ld), .last(ll));
    rmp_front_model i_vfe (.clk, .ready(vr), .valid(vv), .amp(va), .dat(vs), .last(vl));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic wt(input bit lvl);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #2;
            n++;
        end while ((lvl ? lo : vo) !== 1'b1 && n < 400);
        chk({15'h0000, n < 400}, 16'h0001, "no result");
    endtask : wt
    task automatic lvl_rd;
        int r, mx, e, sum;
        int s[$];
        logic [15:0] am, ds;
        r = 0;
        mx = -1;
        sum = 0;
        @(posedge clk);
        #2;
        for (int i = 0; i < 4; i++) begin
            am = 16'($random(seed));
            ds = 16'($random(seed));
            if (am > lamp && (psel == 2'h1 || mx < 0 || (psel == 2'h0 && am > mx))) begin
                r = ds;
                mx = am;
            end
            i_lfe.send(am, ds, i == 3);
        end
        i_lfe.idle();
        q.push_back(r);
        if (q.size() > 3) void'(q.pop_front());
        y = (q.size() == 1) ? r : y + (((r - y) * longint'(coef)) >>> 16);
        foreach (q[k]) sum += q[k];
        s = q;
        s.sort();
        e = ltype == 3'h3 ? s[(s.size() - 1) / 2] : ltype == 3'h1 ? int'(y) :
            ltype == 3'h0 ? r : sum / q.size();
        wt(1);
        chk(lraw, r[15:0], "level distance");
        chk(lout, e[15:0], "filtered level");
    endtask : lvl_rd
    task automatic vel_rd(input logic [15:0] am, input logic [15:0] sp);
        logic ok;
        ok = am >= 16'h7FEE && (dsel == 2'h2 || (dsel == 2'h0 && !sp[15])
            || (dsel == 2'h1 && sp[15]));
        @(posedge clk);
        #2;
        i_vfe.send(am, sp, 1'b1);
        i_vfe.idle();
        wt(0);
        chk({15'h0000, fo}, {15'h0000, ok}, "flow verdict");
        chk(vraw, ok ? sp : 16'h0000, "raw velocity");
        chk(vavg, ok ? sp : 16'h0000, "mean velocity");
        chk({15'h0000, dro}, {15'h0000, ok & sp[15]}, "direction");
        if (ok) chk(snr, 16'hFFFF, "snr");
    endtask : vel_rd
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    // Whole run needs about 1100 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        #2 rst_n = 1;
        for (int t = 0; t < 6; t++) begin
            ltype = (t == 5) ? 3'h1 : t[2:0];
            coef = (t == 5) ? 17'h10000 : 17'h08000;
            psel = 2'(t % 3);
            lamp = {t[2:0], 13'h0000};
            // host changes settings only between readings
            q.delete();
            repeat (5) lvl_rd();
            $display("level test %0d done", t);
        end
        for (int d = 0; d < 4; d++) begin
            dsel = d[1:0];
            // single-bin reading keeps its own speed at any width
            pw = d[1:0];
            vel_rd(16'hF000, 16'($random(seed)));
            vel_rd(16'hF000, 16'hFF00 ^ d[15:0]);
            vel_rd(16'h1000, 16'($random(seed)));
            $display("velocity test %0d done", d);
        end
        close_out();
    end
endmodule : radar_measurement_postprocess_bench
bind rmp_postprocess rmp_chk i_chk (.clk, .rst_n, .snr_thld, .direction_sel, .lvl_filter_type,
    .recursive_coefficient_cmd, .lvl_bin_valid, .lvl_bin_ready, .lvl_bin_last, .vel_out_valid,
    .vel_flow_ok, .vel_dir_out, .vel_snr, .vel_raw, .vel_avg, .lvl_out_valid, .lvl_raw, .lvl_out);

/* File: verification/rmp_chk.sv */
`timescale 1ns/1ps
module rmp_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Settings
    input wire logic [12:0] snr_thld,
    input wire logic [1:0] direction_sel,
    input wire logic [2:0] lvl_filter_type,
    input wire logic [16:0] recursive_coefficient_cmd,
    // Streams
    input wire logic lvl_bin_valid,
    input wire logic lvl_bin_ready,
    input wire logic lvl_bin_last,
    // Results
    input wire logic vel_out_valid,
    input wire logic vel_flow_ok,
    input wire logic vel_dir_out,
    input wire logic [15:0] vel_snr,
    input wire logic signed [15:0] vel_raw,
    input wire logic signed [15:0] vel_avg,
    input wire logic lvl_out_valid,
    input wire logic [15:0] lvl_raw,
    input wire logic [15:0] lvl_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_lvl_pulse:
    assert property (lvl_out_valid |=> !lvl_out_valid) else $error("level pulse too long");
    a_pass_thru:
    assert property (lvl_out_valid && $past(lvl_filter_type) == 3'h0 |-> lvl_out == lvl_raw)
        else $error("unfiltered level changed");
    a_lvl_answer:
    assert property (lvl_bin_valid && lvl_bin_ready && lvl_bin_last && lvl_filter_type == 3'h0
        |-> ##2 lvl_out_valid) else $error("level result late");
    a_iir_unity:
    assert property (lvl_out_valid && $past(lvl_filter_type) == 3'h1
        && $past(recursive_coefficient_cmd) >= 17'h10000 |-> lvl_out == lvl_raw)
        else $error("unit coefficient lags");
    a_rej_zero:
    assert property (vel_out_valid && !vel_flow_ok |-> vel_raw == 16'sh0000
        && vel_avg == 16'sh0000 && !vel_dir_out) else $error("rejected flow reported");
    a_snr_gate:
    assert property (vel_out_valid && vel_flow_ok |-> vel_snr >= {3'h0, snr_thld})
        else $error("flow below snr floor");
    a_dir_in:
    assert property (vel_out_valid && vel_flow_ok && direction_sel == 2'h0
        |-> !vel_dir_out && !vel_raw[15]) else $error("outgoing flow kept");
    a_dir_out:
    assert property (vel_out_valid && vel_flow_ok && direction_sel == 2'h1
        |-> vel_dir_out && vel_raw[15]) else $error("incoming flow kept");
endmodule : rmp_chk

/* File: verification/rmp_front_model.sv */
`timescale 1ns/1ps
module rmp_front_model (
    // Clock and handshake
    input wire logic clk,
    input wire logic ready,
    // Bin stream
    output logic valid = 1'b0,
    output logic [15:0] amp = 16'h0000,
    output logic [15:0] dat = 16'h0000,
    output logic last = 1'b0
);
    // Bin held until ready is sampled high
    task automatic send(input logic [15:0] a, input logic [15:0] d, input logic l);
        valid = 1'b1;
        amp = a;
        dat = d;
        last = l;
        do @(posedge clk); while (ready !== 1'b1);
        #2;
    endtask : send
    // Released lines show the inverse, never the stale bin
    task automatic idle;
        valid = 1'b0;
        amp = ~amp;
        dat = ~dat;
        last = 1'b0;
    endtask : idle
endmodule : rmp_front_model
